// *** hw/fail_monitor_pkg.sv ***
package fail_monitor_pkg;

  // Status register layout.
  localparam int          COUNT_WIDTH      = 4;
  localparam int          COUNT_LSB        = 0;
  localparam int          FAIL_BIT         = 4;
  localparam int          DRIVE_OFF_BIT    = 5;
  localparam int          RESET_FAIL_BIT   = 6;
  localparam logic [3:0]  COUNT_INIT       = 4'h5;
  localparam logic [3:0]  COUNT_MAX        = 4'hF;
  localparam logic [7:0]  STATUS_RESET     = 8'h05;

  // Device states as seen by this block.
  typedef enum logic [3:0] {
    DEV_ACTIVE     = 4'h1,
    DEV_DIAGNOSTIC = 4'h2,
    DEV_SAFE       = 4'h4,
    DEV_RESET      = 4'h8
  } device_state_type;

  // Events arriving from the error signal judge.
  typedef struct packed {
    logic error_seen;
    logic good_response;
  } monitor_event_type;

  // Transition requests toward the device state machine.
  typedef struct packed {
    logic go_safe;
    logic go_reset;
  } state_request_type;

endpackage : fail_monitor_pkg

// *** hw/sticky_flag.sv ***
`timescale 1ns/10ps
// One read-to-clear status flag: set wins over a read clear, and a read
// clears the flag only when its condition is no longer present.
module sticky_flag (
  // Clock and reset.
  input  wire logic clk_in,
  input  wire logic reset_in,
  // Flag control.
  input  wire logic set_in,
  input  wire logic cond_in,
  input  wire logic read_in,
  // Flag value.
  output logic      flag_out
);

  logic next_flag;

  // Next flag value.
  always_comb begin
    next_flag = flag_out;
    if (read_in && !cond_in) begin
      next_flag = 1'b0;
    end
    if (set_in) begin
      next_flag = 1'b1;
    end
  end

  // Flag register.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      flag_out <= 1'b0;
    end else begin
      flag_out <= next_flag;
    end
  end

endmodule : sticky_flag

// *** hw/fail_monitor.sv ***
`timescale 1ns/10ps
// Contract
// - Detected failure sets flag and bumps counter.
// - Error adds one, good response subtracts one.
// - Counter five at init, RESET, DIAGNOSTIC entry.
// - Count at drive-off threshold sets two flags.
// - Drive-off threshold from ACTIVE/DIAGNOSTIC requests SAFE.
// - Count at reset threshold sets two flags.
// - Reset threshold from ACTIVE/DIAGNOSTIC requests RESET.
// - Drive-off flag bit five; flags read-to-clear.
// - Counter in low four bits, readable, writable.
// - Flags latch; read clears only absent condition.
// - Counter writes only in DIAGNOSTIC, unlocked.
module fail_monitor (
  // Clock and reset.
  input  wire logic                              clk_in,
  input  wire logic                              reset_in,
  // Monitor events and configuration.
  input  wire fail_monitor_pkg::monitor_event_type event_in,
  input  wire logic                              self_test_done_in,
  input  wire logic                              monitor_config_select_in,
  input  wire logic                              monitor_enable_bit_in,
  input  wire logic [3:0]                        drive_off_threshold_in,
  input  wire logic [3:0]                        reset_threshold_in,
  // Device state.
  input  wire fail_monitor_pkg::device_state_type device_state_in,
  input  wire logic                              config_lock_in,
  // Register access.
  input  wire logic                              status_read_in,
  input  wire logic                              count_write_in,
  input  wire logic [3:0]                        count_wdata_in,
  output logic [7:0]                             status_out,
  // Requests to the device state machine.
  output fail_monitor_pkg::state_request_type    request_out
);

  logic [3:0]                         count;
  logic [3:0]                         next_count;
  fail_monitor_pkg::device_state_type prev_state;
  logic                               prev_cfg;
  logic                               prev_en;
  logic                               next_prev_cfg;
  logic                               next_prev_en;
  logic                               reload;
  logic                               at_drive_off;
  logic                               at_reset;
  logic                               active_or_diag;
  logic                               fail_flag;
  logic                               drive_off_flag;
  logic                               reset_fail_flag;
  logic [7:0]                         next_status;
  fail_monitor_pkg::state_request_type next_request;

  // Reload events: RESET or DIAGNOSTIC entry, self-test, config toggle, enable rise.
  always_comb begin
    reload = self_test_done_in;
    if (monitor_config_select_in != prev_cfg) begin
      reload = 1'b1;
    end
    if (monitor_enable_bit_in && !prev_en) begin
      reload = 1'b1;
    end
    if ((device_state_in == fail_monitor_pkg::DEV_RESET ||
         device_state_in == fail_monitor_pkg::DEV_DIAGNOSTIC) &&
        device_state_in != prev_state) begin
      reload = 1'b1;
    end
  end

  // Counter next value with saturation and gated software writes.
  always_comb begin
    next_count    = count;
    next_prev_cfg = monitor_config_select_in;
    next_prev_en  = monitor_enable_bit_in;
    if (reload) begin
      next_count = fail_monitor_pkg::COUNT_INIT;
    end else if (count_write_in &&
                 device_state_in == fail_monitor_pkg::DEV_DIAGNOSTIC &&
                 !config_lock_in) begin
      next_count = count_wdata_in;
    end else if (event_in.error_seen && !event_in.good_response) begin
      if (count != fail_monitor_pkg::COUNT_MAX) begin
        next_count = count + 4'h1;
      end
    end else if (event_in.good_response && !event_in.error_seen) begin
      if (count != 4'h0) begin
        next_count = count - 4'h1;
      end
    end
  end

  // Counter and edge-detect registers.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      count      <= fail_monitor_pkg::COUNT_INIT;
      prev_state <= fail_monitor_pkg::DEV_ACTIVE;
      prev_cfg   <= 1'b0;
      prev_en    <= 1'b1;
    end else begin
      count      <= next_count;
      prev_state <= device_state_in;
      prev_cfg   <= next_prev_cfg;
      prev_en    <= next_prev_en;
    end
  end

  // Threshold comparisons on the registered count.
  assign at_drive_off   = (count >= drive_off_threshold_in);
  assign at_reset       = (count >= reset_threshold_in);
  assign active_or_diag = (device_state_in == fail_monitor_pkg::DEV_ACTIVE) ||
                          (device_state_in ==
                           fail_monitor_pkg::DEV_DIAGNOSTIC);

  // Failure flag: set on each detected error or any threshold hit.
  sticky_flag fail_bit (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .set_in   (event_in.error_seen | at_drive_off | at_reset),
    .cond_in  (at_drive_off | at_reset),
    .read_in  (status_read_in),
    .flag_out (fail_flag)
  );

  // Drive-off flag follows the drive-off threshold.
  sticky_flag drive_off_bit (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .set_in   (at_drive_off),
    .cond_in  (at_drive_off),
    .read_in  (status_read_in),
    .flag_out (drive_off_flag)
  );

  // Reset-fail flag follows the reset threshold.
  sticky_flag reset_fail_bit (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .set_in   (at_reset),
    .cond_in  (at_reset),
    .read_in  (status_read_in),
    .flag_out (reset_fail_flag)
  );

  // Status image and transition requests, next values.
  always_comb begin
    next_status = 8'h00;
    next_status[fail_monitor_pkg::COUNT_LSB +: 4] = next_count;
    next_status[fail_monitor_pkg::FAIL_BIT]       = fail_flag;
    next_status[fail_monitor_pkg::DRIVE_OFF_BIT]  = drive_off_flag;
    next_status[fail_monitor_pkg::RESET_FAIL_BIT] = reset_fail_flag;
    next_request.go_safe  = at_drive_off && active_or_diag;
    next_request.go_reset = at_reset && active_or_diag;
  end

  // Output registers.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      status_out  <= fail_monitor_pkg::STATUS_RESET;
      request_out <= '0;
    end else begin
      status_out  <= next_status;
      request_out <= next_request;
    end
  end

  // Error with no reload or write raises the count by one next cycle.
  property p_inc;
    @(posedge clk_in) disable iff (reset_in)
    (event_in.error_seen && !event_in.good_response && !reload &&
     !count_write_in && count != 4'hF) |=> (count == $past(count) + 4'h1);
  endproperty
  a_inc: assert property (p_inc)
    else $error("count did not increment");

  property p_dec;
    @(posedge clk_in) disable iff (reset_in)
    (event_in.good_response && !event_in.error_seen && !reload &&
     !count_write_in && count != 4'h0) |=> (count == $past(count) - 4'h1);
  endproperty
  a_dec: assert property (p_dec)
    else $error("count did not decrement");

  property p_sat;
    @(posedge clk_in) disable iff (reset_in)
    (count == 4'hF && !reload && !count_write_in) |=> (count != 4'h0);
  endproperty
  a_sat: assert property (p_sat) else $error("count wrapped");

  property p_reload;
    @(posedge clk_in) disable iff (reset_in)
    reload |=> (count == 4'h5);
  endproperty
  a_reload: assert property (p_reload)
    else $error("no reload to five");

  property p_fail_set;
    @(posedge clk_in) disable iff (reset_in)
    event_in.error_seen |=> fail_flag;
  endproperty
  a_fail_set: assert property (p_fail_set)
    else $error("fail flag missed");

  property p_drive_off;
    @(posedge clk_in) disable iff (reset_in)
    at_drive_off |=> (drive_off_flag && fail_flag);
  endproperty
  a_drive_off: assert property (p_drive_off)
    else $error("drive-off flag");

  property p_reset_flag;
    @(posedge clk_in) disable iff (reset_in)
    at_reset |=> (reset_fail_flag && fail_flag);
  endproperty
  a_reset_flag: assert property (p_reset_flag)
    else $error("reset flag");

  property p_safe_req;
    @(posedge clk_in) disable iff (reset_in)
    (at_drive_off && active_or_diag) |=> request_out.go_safe;
  endproperty
  a_safe_req: assert property (p_safe_req)
    else $error("no safe request");

  property p_reset_req;
    @(posedge clk_in) disable iff (reset_in)
    !active_or_diag |=> !request_out.go_reset;
  endproperty
  a_reset_req: assert property (p_reset_req)
    else $error("bad reset req");

  // A reset-threshold hit in ACTIVE or DIAGNOSTIC must raise the request.
  property p_reset_go;
    @(posedge clk_in) disable iff (reset_in)
    (at_reset && active_or_diag) |=> request_out.go_reset;
  endproperty
  a_reset_go: assert property (p_reset_go)
    else $error("no reset request");

  property p_locked;
    @(posedge clk_in) disable iff (reset_in)
    (count_write_in && config_lock_in && !reload &&
     !event_in.error_seen && !event_in.good_response) |=> $stable(count);
  endproperty
  a_locked: assert property (p_locked)
    else $error("locked write took");

  property p_latch;
    @(posedge clk_in) disable iff (reset_in)
    (drive_off_flag && !status_read_in) |=> drive_off_flag;
  endproperty
  a_latch: assert property (p_latch) else $error("flag not latched");

  property p_image;
    @(posedge clk_in) disable iff (reset_in)
    1'b1 |=> (status_out[3:0] == count && status_out[7] == 1'b0);
  endproperty
  a_image: assert property (p_image)
    else $error("status image wrong");

endmodule : fail_monitor

// *** test/mcu_partner.sv ***
`timescale 1ns/10ps
// Behavioural microcontroller: each answer it gives is judged right or
// wrong, and the judge turns it into a one-cycle event pulse.
module mcu_partner (
  // Clock.
  input  wire logic                          clk_in,
  // Judged answers toward the monitor.
  output fail_monitor_pkg::monitor_event_type event_out
);
  initial event_out = '0;

  // Sends n answers with gap idle cycles after each; gap 0 keeps the
  // pulse high so back-to-back answers never reassign in one step.
  task automatic answer(input int n, input logic wrong, input int gap);
    for (int i = 0; i < n; i++) begin
      event_out.error_seen    <= wrong;
      event_out.good_response <= !wrong;
      @(posedge clk_in);
      if (gap > 0 || i == n - 1) event_out <= '0;
      repeat (gap) @(posedge clk_in);
    end
  endtask : answer
endmodule : mcu_partner

// *** test/fail_monitor_tb.sv ***
`timescale 1ns/10ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
  mismatches++; \
  $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); \
  end end
// Self-checking bench for the failure counter and its latched flags.
module fail_monitor_tb;
  logic                               clk_in = 1'b0;
  logic                               reset_in = 1'b1;
  fail_monitor_pkg::monitor_event_type ev;
  logic                               test_done = 1'b0;
  logic                               cfg_sel = 1'b0;
  logic                               en_bit = 1'b1;
  fail_monitor_pkg::device_state_type state = fail_monitor_pkg::DEV_ACTIVE;
  logic                               lock = 1'b0;
  logic                               rd = 1'b0;
  logic                               wr = 1'b0;
  logic [3:0]                         wdata = 4'h0;
  logic [3:0]                         drive_th = 4'hA;
  logic [3:0]                         reset_th = 4'hC;
  logic [7:0]                         status;
  fail_monitor_pkg::state_request_type req;
  int                                 mismatches = 0;
  int                                 checks_done = 0;

  // Free-running 100 MHz clock.
  always #5 clk_in = ~clk_in;

  mcu_partner partner (.clk_in(clk_in), .event_out(ev));

  fail_monitor uut (
    .clk_in(clk_in), .reset_in(reset_in), .event_in(ev),
    .self_test_done_in(test_done), .monitor_config_select_in(cfg_sel),
    .monitor_enable_bit_in(en_bit), .drive_off_threshold_in(drive_th),
    .reset_threshold_in(reset_th), .device_state_in(state),
    .config_lock_in(lock), .status_read_in(rd), .count_write_in(wr),
    .count_wdata_in(wdata), .status_out(status), .request_out(req)
  );

  // Lets the registered results land, then samples off the edge.
  task automatic settle();
    repeat (4) @(posedge clk_in);
    #1;
  endtask : settle

  // One status register read strobe.
  task automatic read_status();
    @(posedge clk_in);
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    settle();
  endtask : read_status

  // Counter write strobe with the given data.
  task automatic write_count(input logic [3:0] value);
    @(posedge clk_in);
    wr    <= 1'b1;
    wdata <= value;
    @(posedge clk_in);
    wr <= 1'b0;
    settle();
  endtask : write_count

  task automatic errors(input int n, input int gap);
    @(posedge clk_in);
    partner.answer(n, 1'b1, gap);
    settle();
  endtask : errors

  task automatic goods(input int n, input int gap);
    @(posedge clk_in);
    partner.answer(n, 1'b0, gap);
    settle();
  endtask : goods

  // Errors raise the count and latch the failure flag until a read.
  task automatic test_count_and_flag();
    errors(3, 1);
    `CHK(status, 8'h18)
    read_status();
    `CHK(status, 8'h08)
    goods(2, 0);
    `CHK(status[3:0], 4'h6)
    goods(8, 0);
    `CHK(status[3:0], 4'h0)
    $display("test count_and_flag done");
  endtask : test_count_and_flag

  // Thresholds raise flags and requests, then the count saturates.
  task automatic test_thresholds();
    errors(10, 0);
    `CHK(status[5:4], 2'b11)
    `CHK(req, 2'b10)
    read_status();
    `CHK(status[5], 1'b1)
    errors(2, 2);
    `CHK(status[6:4], 3'b111)
    `CHK(req, 2'b11)
    errors(5, 0);
    `CHK(status[3:0], 4'hF)
    @(posedge clk_in);
    state <= fail_monitor_pkg::DEV_RESET;
    settle();
    `CHK(status[3:0], 4'h5)
    read_status();
    `CHK(status, 8'h05)
    @(posedge clk_in);
    state <= fail_monitor_pkg::DEV_SAFE;
    errors(5, 1);
    `CHK(req, 2'b00)
    $display("test thresholds done");
  endtask : test_thresholds

  // Self-test completion, config change and enable rise all reload.
  task automatic test_reloads();
    @(posedge clk_in);
    test_done <= 1'b1;
    @(posedge clk_in);
    test_done <= 1'b0;
    settle();
    `CHK(status[3:0], 4'h5)
    errors(1, 0);
    @(posedge clk_in);
    cfg_sel <= 1'b1;
    settle();
    `CHK(status[3:0], 4'h5)
    errors(2, 0);
    @(posedge clk_in);
    en_bit <= 1'b0;
    @(posedge clk_in);
    en_bit <= 1'b1;
    settle();
    `CHK(status[3:0], 4'h5)
    $display("test reloads done");
  endtask : test_reloads

  // Counter writes only land in DIAGNOSTIC with the lock open.
  task automatic test_writes();
    errors(1, 0);
    write_count(4'h3);
    `CHK(status[3:0], 4'h6)
    @(posedge clk_in);
    state <= fail_monitor_pkg::DEV_DIAGNOSTIC;
    lock  <= 1'b1;
    settle();
    `CHK(status[3:0], 4'h5)
    write_count(4'h3);
    `CHK(status[3:0], 4'h5)
    @(posedge clk_in);
    lock <= 1'b0;
    write_count(4'h3);
    `CHK(status[3:0], 4'h3)
    // A lowered threshold in DIAGNOSTIC must request SAFE as well.
    @(posedge clk_in);
    drive_th <= 4'h3;
    settle();
    `CHK(req, 2'b10)
    $display("test writes done");
  endtask : test_writes

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results

  // Main sequence after a 20-cycle reset.
  initial begin
    repeat (20) @(posedge clk_in);
    reset_in <= 1'b0;
    #1;
    `CHK(status, fail_monitor_pkg::STATUS_RESET)
    `CHK(req, 2'b00)
    test_count_and_flag();
    test_thresholds();
    test_reloads();
    test_writes();
    results();
  end

  // Cuts a hang short; the tests need well under 1000 cycles.
  initial begin
    #100us;
    mismatches++;
    results();
  end
endmodule : fail_monitor_tb
